// file: hdlc_channel_event_flags.v
// per-channel event flags, masks and status of a serial hdlc controller
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "hdlc_event_regs.vh"

module hdlc_channel_event_flags (
    input  wire        clk_sys_i,
    input  wire        resetn_i,
    // apb slave
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output wire        pready_o,
    output reg  [31:0] prdata_o,
    output wire        pslverr_o,
    // receiver events, one-cycle pulses from same clock
    input  wire        rx_byte_dropped_i,
    input  wire        rx_frame_discarded_i,
    input  wire        rx_bad_nr_i,
    input  wire        rx_sframe_info_i,
    input  wire        rx_rr_i,
    input  wire        rx_rnr_i,
    input  wire        rx_addr_match_i,
    input  wire        rx_open_flag_i,
    input  wire        addr_recog_mode_i,
    input  wire        rx_frame_end_i,
    input  wire        rx_len_abort_i,
    input  wire        rx_signal_unit_i,
    input  wire [5:0]  rx_fifo_level_i,
    input  wire        rx_message_complete_cmd_i,
    // transmitter and timer events
    input  wire        timer_expired_i,
    input  wire        tx_nack_i,
    input  wire        tx_collision_i,
    input  wire        tx_cts_lost_i,
    input  wire [11:0] tx_bits_sent_i,
    input  wire        tx_reset_cmd_i,
    input  wire        tx_fifo_space_i,
    input  wire        tx_last_bit_i,
    input  wire        tx_fifo_empty_i,
    input  wire        tx_iframe_done_i,
    input  wire        tx_fifo_dry_i,
    input  wire        tx_frame_end_seen_i,
    // line inputs from pins and other clocks
    input  wire        cts_i,
    input  wire        carrier_detect_i,
    input  wire        tx_clk_present_i,
    input  wire        rx_clk_present_i,
    input  wire        dpll_locked_i,
    // outputs to datapath
    output reg         tx_abort_o,
    output wire        tx_stop_o,
    output wire        rx_hold_o,
    output wire        tx_dpll_halt_o,
    output wire        rx_fifo_free_o,
    output reg  [7:0]  rx_frame_status_byte_o,
    output reg         rx_status_write_o,
    output wire        irq_o
);

    // pending flags, one register per status word
    reg  [7:0] status0_r;
    reg  [7:0] status1_r;
    reg  [7:0] status2_r;

    // event masks; a one keeps the event off irq_o
    reg  [7:0] mask0_r;
    reg  [7:0] mask1_r;
    reg  [7:0] mask2_r;

    // own control word: modes, threshold, show-masked
    reg  [7:0] control_r;

    // receive and transmit side state
    reg        frame_lost_r;
    reg        remote_not_ready_r;
    reg        tx_stopped_r;
    reg        rx_byte_count_high_r;
    reg  [4:0] rx_byte_count_low_r;
    reg  [7:0] su_count_r;
    reg        rx_fifo_owned_r;
    reg        pool_full_seen_r;

    // pin level synchronisers, only bit 1 is read
    reg  [1:0] cts_sync_r;
    reg  [1:0] cd_sync_r;
    reg  [1:0] txc_sync_r;
    reg  [1:0] rxc_sync_r;
    reg  [1:0] lock_sync_r;

    // previous synced levels for edge detection
    reg        cts_prev_r;
    reg        cd_prev_r;
    reg        lock_prev_r;

    // one-cycle raw events before masking
    reg  [7:0] ev0;
    reg  [7:0] ev1;
    reg  [7:0] ev2;

    // threshold decode results
    reg  [4:0] fill_mask;
    reg  [5:0] threshold;

    wire       auto_mode  = control_r[`C_AUTO_MODE];
    wire       show_mask  = control_r[`C_SHOW_MASKED];
    wire       dpll_coded = control_r[`C_DPLL_CODED];
    wire [1:0] thr_sel    = control_r[`C_THRESHOLD_LO+1:`C_THRESHOLD_LO];
    wire [7:0] idx        = paddr_i[9:2];
    wire       rd_access  = psel_i & penable_i & ~pwrite_i;
    wire       wr_access  = psel_i & penable_i & pwrite_i;
    wire       cts_s      = cts_sync_r[1];
    wire       cd_s       = cd_sync_r[1];
    wire       txc_s      = txc_sync_r[1];
    wire       rxc_s      = rxc_sync_r[1];
    wire       lock_s     = lock_sync_r[1];
    wire       sync_lost  = dpll_coded & ~lock_s;

    // zero-wait apb slave; unmapped reads return zero without error
    // reads and writes finish in the access cycle
    assign pready_o  = 1'b1;
    assign pslverr_o = 1'b0;

    // two-flop synchronisers for pin-side levels
    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            cts_sync_r  <= 2'h0;
            cd_sync_r   <= 2'h0;
            txc_sync_r  <= 2'h0;
            rxc_sync_r  <= 2'h0;
            // lock starts high: no false loss after reset
            lock_sync_r <= 2'h3;
        end else begin
            cts_sync_r  <= {cts_sync_r[0], cts_i};
            cd_sync_r   <= {cd_sync_r[0], carrier_detect_i};
            txc_sync_r  <= {txc_sync_r[0], tx_clk_present_i};
            rxc_sync_r  <= {rxc_sync_r[0], rx_clk_present_i};
            lock_sync_r <= {lock_sync_r[0], dpll_locked_i};
        end
    end

    // threshold decode: 00=1, 01=4, 10=16, 11=32 bytes; count field width follows
    always @* begin
        case (thr_sel)
            2'h0: begin
                threshold = 6'h01;
                fill_mask = 5'h01;
            end
            2'h1: begin
                threshold = 6'h04;
                fill_mask = 5'h03;
            end
            2'h2: begin
                threshold = 6'h10;
                fill_mask = 5'h0F;
            end
            default: begin
                threshold = 6'h20;
                fill_mask = 5'h1F;
            end
        endcase
    end

    // raw event vectors, one-cycle
    always @* begin
        ev0 = 8'h00;
        ev1 = 8'h00;
        ev2 = 8'h00;
        // receive events
        ev0[`B_RX_DATA_LOST]     = rx_byte_dropped_i & ~frame_lost_r;
        ev0[`B_RX_FRAME_DROPPED] = rx_frame_discarded_i;
        ev0[`B_PROTOCOL_ERROR]   = auto_mode & (rx_bad_nr_i | rx_sframe_info_i);
        ev0[`B_REMOTE_RX_CHANGE] = auto_mode &
            ((rx_rr_i & remote_not_ready_r) | (rx_rnr_i & ~remote_not_ready_r));
        ev0[`B_RX_POOL_FULL]     = ~pool_full_seen_r & ~sync_lost &
                                   (rx_fifo_level_i >= threshold);
        ev0[`B_RX_MESSAGE_END]   = rx_frame_end_i & ~sync_lost;
        ev0[`B_RX_FRAME_START]   = ~sync_lost & (addr_recog_mode_i ?
                                   rx_addr_match_i : rx_open_flag_i);
        ev0[`B_FRAME_LEN_EXCEEDED] = control_r[`C_LEN_CHECK_EN] & rx_len_abort_i;

        // transmit and timer events
        ev1[`B_TIMER_EXPIRED]    = timer_expired_i;
        ev1[`B_CTS_CHANGE]       = txc_s & (cts_s ^ cts_prev_r);
        ev1[`B_TX_REPEAT]        = (auto_mode & tx_nack_i) |
            ((tx_collision_i | tx_cts_lost_i) &
             (tx_bits_sent_i >= `TX_REPEAT_MIN_BITS));
        ev1[`B_TX_POOL_READY]    = txc_s & (tx_reset_cmd_i | tx_fifo_space_i);
        ev1[`B_ALL_SENT]         = auto_mode ? tx_iframe_done_i :
                                   (tx_last_bit_i & tx_fifo_empty_i);
        ev1[`B_TX_UNDERRUN]      = tx_fifo_dry_i & ~tx_frame_end_seen_i & ~tx_stopped_r;
        ev1[`B_SU_OVERFLOW]      = rx_signal_unit_i &
                                   ({1'b0, su_count_r} == (`SU_WRAP_COUNT - 9'h001));

        // line events
        ev2[`B_DPLL_SYNC_LOST]   = dpll_coded & lock_prev_r & ~lock_s;
        ev2[`B_CARRIER_CHANGE]   = rxc_s & (cd_s ^ cd_prev_r);
    end

    // status flags: set wins over read-clear; masked events hidden unless shown
    // a flag set in the read cycle survives for the next read
    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            status0_r <= 8'h00;
            status1_r <= 8'h00;
            status2_r <= 8'h00;
        end else begin
            // word 0: receive events
            status0_r <= ((rd_access && idx == `IDX_EVENT_STATUS_0) ? 8'h00 : status0_r)
                         | (ev0 & (~mask0_r | {8{show_mask}}));
            // word 1: bit 0 has no event
            status1_r <= ((rd_access && idx == `IDX_EVENT_STATUS_1) ? 8'h00 : status1_r)
                         | (ev1 & (~mask1_r | {8{show_mask}}) & 8'hFE);
            // word 2: only bits 1:0 exist
            status2_r <= ((rd_access && idx == `IDX_EVENT_STATUS_2) ? 8'h00 : status2_r)
                         | (ev2 & (~mask2_r | {8{show_mask}}) & 8'h03);
        end
    end

    // interrupt only from unmasked pending flags
    assign irq_o = |(status0_r & ~mask0_r) | |(status1_r & ~mask1_r)
                   | |(status2_r & ~mask2_r);

    // receive side state: lost-data tracking, byte counts, remote state, fifo ownership
    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            frame_lost_r           <= 1'b0;
            remote_not_ready_r     <= 1'b0;
            rx_byte_count_high_r   <= 1'b0;
            rx_byte_count_low_r    <= 5'h00;
            rx_fifo_owned_r        <= 1'b0;
            pool_full_seen_r       <= 1'b0;
            rx_frame_status_byte_o <= 8'h00;
            rx_status_write_o      <= 1'b0;
            su_count_r             <= 8'h00;
        end else begin
            rx_status_write_o <= 1'b0;
            // drop bytes while full; frame stays marked lost until its end
            if (rx_byte_dropped_i)
                frame_lost_r <= 1'b1;
            // status byte and counts latched at frame end
            if (rx_frame_end_i) begin
                frame_lost_r           <= 1'b0;
                rx_frame_status_byte_o <= {1'b0, frame_lost_r | rx_byte_dropped_i,
                                           1'b0, rx_len_abort_i, 4'h0};
                rx_status_write_o      <= 1'b1;
                rx_byte_count_high_r   <= control_r[`C_DMA_MODE] &
                                          (frame_lost_r | rx_byte_dropped_i);
                rx_byte_count_low_r    <= rx_fifo_level_i[4:0] & fill_mask;
                rx_fifo_owned_r        <= 1'b1;
            end
            // fifo space reused only after the complete command;
            // a frame ending in the same cycle claims it again
            if (rx_message_complete_cmd_i)
                rx_fifo_owned_r <= rx_frame_end_i;
            // pool full reported once; a new crossing beats the command
            if (ev0[`B_RX_POOL_FULL])
                pool_full_seen_r <= 1'b1;
            else if (rx_message_complete_cmd_i)
                pool_full_seen_r <= 1'b0;
            // remote receiver state follows rr/rnr in automatic mode
            if (auto_mode && rx_rnr_i)
                remote_not_ready_r <= 1'b1;
            else if (auto_mode && rx_rr_i)
                remote_not_ready_r <= 1'b0;
            // counter wraps at 256 regardless of unit correctness
            if (rx_signal_unit_i)
                su_count_r <= su_count_r + 8'h01;
        end
    end

    // datapath controls; reception and dpll transmit
    // halt together while lock is lost
    assign rx_fifo_free_o = ~rx_fifo_owned_r;
    assign rx_hold_o      = sync_lost;
    assign tx_dpll_halt_o = sync_lost;
    assign tx_stop_o      = tx_stopped_r;

    // transmitter underrun: one abort pulse, then stay stopped until status 1 read
    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            tx_stopped_r <= 1'b0;
            tx_abort_o   <= 1'b0;
            cts_prev_r   <= 1'b0;
            cd_prev_r    <= 1'b0;
            lock_prev_r  <= 1'b1;
        end else begin
            // a stopped transmitter raises no new underrun
            tx_abort_o  <= ev1[`B_TX_UNDERRUN];
            if (ev1[`B_TX_UNDERRUN])
                tx_stopped_r <= 1'b1;
            else if (rd_access && idx == `IDX_EVENT_STATUS_1)
                tx_stopped_r <= 1'b0;
            // edge references follow only while the clock is there
            if (txc_s)
                cts_prev_r <= cts_s;
            if (rxc_s)
                cd_prev_r  <= cd_s;
            // lock reference always follows, so a regained lock re-arms
            lock_prev_r <= lock_s;
        end
    end

    // register writes
    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            mask0_r   <= `RST_EVENT_MASK_0;
            mask1_r   <= `RST_EVENT_MASK_1;
            mask2_r   <= `RST_EVENT_MASK_2;
            control_r <= `RST_CONTROL | ({6'h00, `RST_THRESHOLD} << `C_THRESHOLD_LO);
        end else if (wr_access) begin
            case (idx)
                `IDX_EVENT_MASK_0: mask0_r   <= pwdata_i[7:0];
                // mask bits with no event behind them are forced to one by writes
                `IDX_EVENT_MASK_1: mask1_r   <= pwdata_i[7:0] | 8'h01;
                `IDX_EVENT_MASK_2: mask2_r   <= pwdata_i[7:0] | 8'hFC;
                // control bit 7 unused, reads zero
                `IDX_CONTROL:      control_r <= pwdata_i[7:0] & 8'h7F;
                // unmapped indices ignore writes
                default: ;
            endcase
        end
    end

    // read mux
    always @* begin
        case (idx)
            `IDX_EVENT_STATUS_0: prdata_o = {24'h0, status0_r};
            `IDX_EVENT_STATUS_1: prdata_o = {24'h0, status1_r};
            `IDX_EVENT_STATUS_2: prdata_o = {24'h0, status2_r};
            `IDX_EVENT_MASK_0:   prdata_o = {24'h0, mask0_r};
            `IDX_EVENT_MASK_1:   prdata_o = {24'h0, mask1_r};
            `IDX_EVENT_MASK_2:   prdata_o = {24'h0, mask2_r};
            `IDX_CONTROL:        prdata_o = {24'h0, control_r};
            // line status: synced levels and stop states
            `IDX_LINE_STATUS:    prdata_o = {26'h0, sync_lost & dpll_coded, sync_lost,
                                             tx_stopped_r, remote_not_ready_r, cd_s, cts_s};
            `IDX_RX_BYTE_COUNT:  prdata_o = {16'h0, 7'h0, rx_byte_count_high_r,
                                             3'h0, rx_byte_count_low_r};
            `IDX_SU_COUNT:       prdata_o = {24'h0, su_count_r};
            // unmapped indices read zero
            default:             prdata_o = 32'h0;
        endcase
    end

endmodule
`default_nettype wire

// file: hdlc_event_regs.vh
// register offsets, field positions and reset values of the channel event block
`ifndef HDLC_EVENT_REGS_VH
`define HDLC_EVENT_REGS_VH

// printed offsets are not all multiples of four: these are word indices
`define IDX_EVENT_STATUS_0   8'h50
`define IDX_EVENT_STATUS_1   8'h51
`define IDX_EVENT_STATUS_2   8'h52
`define IDX_EVENT_MASK_0     8'h54
`define IDX_EVENT_MASK_1     8'h55
`define IDX_EVENT_MASK_2     8'h56
`define IDX_CONTROL          8'h60
`define IDX_LINE_STATUS      8'h61
`define IDX_RX_BYTE_COUNT    8'h62
`define IDX_SU_COUNT         8'h63

// reset values
`define RST_EVENT_MASK_0     8'hFF
`define RST_EVENT_MASK_1     8'hFF
`define RST_EVENT_MASK_2     8'h03
`define RST_CONTROL          8'h00
`define RST_THRESHOLD        2'h3

// status 0 bit positions
`define B_RX_DATA_LOST       7
`define B_RX_FRAME_DROPPED   6
`define B_PROTOCOL_ERROR     5
`define B_REMOTE_RX_CHANGE   4
`define B_RX_POOL_FULL       3
`define B_RX_MESSAGE_END     2
`define B_RX_FRAME_START     1
`define B_FRAME_LEN_EXCEEDED 0
// status 1 bit positions
`define B_TIMER_EXPIRED      7
`define B_CTS_CHANGE         6
`define B_TX_REPEAT          5
`define B_TX_POOL_READY      4
`define B_ALL_SENT           3
`define B_TX_UNDERRUN        2
`define B_SU_OVERFLOW        1
// status 2 bit positions
`define B_DPLL_SYNC_LOST     1
`define B_CARRIER_CHANGE     0

// control register fields
`define C_SHOW_MASKED        0
`define C_AUTO_MODE          1
`define C_LEN_CHECK_EN       2
`define C_DMA_MODE           3
`define C_DPLL_CODED         4
`define C_THRESHOLD_LO       5

// line status fields
`define L_CTS                0
`define L_CARRIER            1
`define L_REMOTE_NOT_READY   2
`define L_TX_STOPPED         3
`define L_RX_HELD            4
`define L_TX_HALTED          5

// 14.5 bytes expressed in bits
`define TX_REPEAT_MIN_BITS   12'h074
`define SU_WRAP_COUNT        9'h100

`endif

// file: hdlc_channel_event_flags_asserts.sv
// concurrent checks on the ports of the channel event block
`timescale 1ns/100ps
`default_nettype none
`include "hdlc_event_regs.vh"
module hdlc_channel_event_flags_asserts (
    input wire logic        clk_sys_i,
    input wire logic        resetn_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic        rx_byte_dropped_i,
    input wire logic        rx_frame_end_i,
    input wire logic        rx_message_complete_cmd_i,
    input wire logic        tx_fifo_dry_i,
    input wire logic        tx_frame_end_seen_i,
    input wire logic        dpll_locked_i,
    input wire logic        tx_abort_o,
    input wire logic        tx_stop_o,
    input wire logic        rx_hold_o,
    input wire logic        tx_dpll_halt_o,
    input wire logic        rx_fifo_free_o,
    input wire logic [7:0]  rx_frame_status_byte_o,
    input wire logic        rx_status_write_o,
    input wire logic        irq_o
);
    logic all_masked_r;
    wire  s1_rd = psel_i && penable_i && !pwrite_i
                  && paddr_i == {2'b00, `IDX_EVENT_STATUS_1, 2'b00};
    wire  mask_wr = psel_i && penable_i && pwrite_i && paddr_i[9:2] >= `IDX_EVENT_MASK_0
                    && paddr_i[9:2] <= `IDX_EVENT_MASK_2;

    // conservative: any mask write ends the all-masked window
    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            all_masked_r <= 1'b1;
        end else if (mask_wr) begin
            all_masked_r <= 1'b0;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    sequence lost_frame_s;
        rx_byte_dropped_i ##1 rx_frame_end_i;
    endsequence
    sequence underrun_s;
        tx_fifo_dry_i && !tx_frame_end_seen_i && !tx_stop_o;
    endsequence

    status_write_a: assert property (rx_frame_end_i |=> rx_status_write_o)
        else $error("status byte not stored after frame end");
    status_cause_a: assert property (rx_status_write_o |-> $past(rx_frame_end_i))
        else $error("status byte stored without frame end");
    lost_mark_a: assert property (lost_frame_s |=> rx_status_write_o && rx_frame_status_byte_o[6])
        else $error("lost data not marked in status byte");
    underrun_abort_a: assert property (underrun_s |=> tx_abort_o && tx_stop_o)
        else $error("underrun without abort and stop");
    abort_cause_a: assert property (tx_abort_o |-> $past(tx_fifo_dry_i && !tx_frame_end_seen_i))
        else $error("abort without underrun");
    stop_hold_a: assert property (tx_stop_o && !s1_rd |=> tx_stop_o)
        else $error("transmitter stop cleared without status read");
    masked_quiet_a: assert property (all_masked_r |-> !irq_o)
        else $error("interrupt while every event is masked");
    fifo_block_a: assert property (rx_frame_end_i |=> !rx_fifo_free_o)
        else $error("fifo space free right after frame end");
    fifo_hold_a: assert property (!rx_fifo_free_o && !rx_message_complete_cmd_i |=> !rx_fifo_free_o)
        else $error("fifo space freed without complete command");
    fifo_release_a: assert property (rx_message_complete_cmd_i && !rx_frame_end_i |-> ##[0:1] rx_fifo_free_o)
        else $error("fifo space not freed by complete command");
    lock_release_a: assert property (dpll_locked_i [*5] |-> !rx_hold_o)
        else $error("reception held while dpll locked");
    halt_pair_a: assert property (rx_hold_o |-> tx_dpll_halt_o)
        else $error("dpll clocked transmit not halted with reception");
endmodule

bind hdlc_channel_event_flags hdlc_channel_event_flags_asserts u_asserts (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .rx_byte_dropped_i(rx_byte_dropped_i),
    .rx_frame_end_i(rx_frame_end_i), .rx_message_complete_cmd_i(rx_message_complete_cmd_i),
    .tx_fifo_dry_i(tx_fifo_dry_i), .tx_frame_end_seen_i(tx_frame_end_seen_i),
    .dpll_locked_i(dpll_locked_i), .tx_abort_o(tx_abort_o), .tx_stop_o(tx_stop_o),
    .rx_hold_o(rx_hold_o), .tx_dpll_halt_o(tx_dpll_halt_o), .rx_fifo_free_o(rx_fifo_free_o),
    .rx_frame_status_byte_o(rx_frame_status_byte_o), .rx_status_write_o(rx_status_write_o),
    .irq_o(irq_o)
);
`default_nettype wire

// file: test_hdlc_channel_event_flags.sv
// self-checking bench for the channel event block
`timescale 1ns/100ps
`default_nettype none
`include "hdlc_event_regs.vh"
module test_hdlc_channel_event_flags;
    logic        clk_sys_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h00000000;
    logic [19:0] pv = 20'h00000;
    logic [5:0]  rx_fifo_level_i = 6'h00;
    logic [11:0] tx_bits_sent_i = 12'h000;
    logic        tx_frame_end_seen_i = 1'b0, cts_i = 1'b0, carrier_detect_i = 1'b0;
    logic        dpll_locked_i = 1'b1;
    wire         pready_o, pslverr_o, tx_abort_o, tx_stop_o, rx_hold_o, tx_dpll_halt_o;
    wire         rx_fifo_free_o, rx_status_write_o, irq_o;
    wire  [31:0] prdata_o;
    wire  [7:0]  rx_frame_status_byte_o;
    logic [7:0]  expq[$];
    logic [7:0]  v;
    logic [31:0] tbl [0:24];
    int          n_mismatch = 0, compares = 0, seed = 40;

    always #2.5 clk_sys_i = ~clk_sys_i;

    // event pulses share one vector so a table row can pick any of them
    hdlc_channel_event_flags uut (
        .*,
        .rx_byte_dropped_i(pv[0]), .rx_frame_discarded_i(pv[1]), .rx_bad_nr_i(pv[2]),
        .rx_sframe_info_i(pv[3]), .rx_rr_i(pv[4]), .rx_rnr_i(pv[5]), .rx_addr_match_i(pv[6]),
        .rx_open_flag_i(pv[7]), .rx_frame_end_i(pv[8]), .rx_len_abort_i(pv[9]),
        .rx_signal_unit_i(pv[10]), .rx_message_complete_cmd_i(pv[11]),
        .timer_expired_i(pv[12]), .tx_nack_i(pv[13]), .tx_collision_i(pv[14]),
        .tx_cts_lost_i(pv[15]), .tx_reset_cmd_i(pv[16]), .tx_fifo_space_i(pv[17]),
        .tx_iframe_done_i(pv[18]), .tx_fifo_dry_i(pv[19]), .addr_recog_mode_i(1'b0),
        .tx_last_bit_i(1'b0), .tx_fifo_empty_i(1'b1), .tx_clk_present_i(1'b1),
        .rx_clk_present_i(1'b1)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        if (n_mismatch == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // read data judged at the completing edge, before its read-clear lands
    always @(posedge clk_sys_i) begin
        if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i && expq.size() > 0) begin
            check(prdata_o[7:0], expq.pop_front());
        end
        if (psel_i && penable_i && pready_o === 1'b1) begin
            check({7'h00, pslverr_o}, 8'h00);
        end
    end

    // one apb transfer; a read notes its expected byte for the monitor
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        @(posedge clk_sys_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= w;
        paddr_i   <= {2'b00, idx, 2'b00};
        pwdata_i  <= {24'h000000, d};
        if (!w)
            expq.push_back(d);
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (pready_o !== 1'b1 && n < 16);
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        if (pready_o !== 1'b1) begin
            n_mismatch++;
            wrap_up();
        end
    endtask

    task automatic pulse2(input logic [19:0] a, input logic [19:0] b);
        @(posedge clk_sys_i);
        pv <= a;
        @(posedge clk_sys_i);
        pv <= b;
        @(posedge clk_sys_i);
        pv <= 20'h00000;
    endtask

    // row: pulse index, level changes, status word, expected flags
    task automatic ev(input logic [31:0] r);
        @(posedge clk_sys_i);
        tx_bits_sent_i      <= r[16] ? 12'h073 : 12'h074; // 115 or 116 bits sent
        tx_frame_end_seen_i <= r[17];
        rx_fifo_level_i     <= r[18] ? 6'h20 : 6'h1F;
        cts_i               <= cts_i ^ r[19];
        carrier_detect_i    <= carrier_detect_i ^ r[20];
        dpll_locked_i       <= dpll_locked_i ^ r[21];
        pulse2(20'h00001 << r[28:24], 20'h00000);
        repeat (8) @(posedge clk_sys_i); // covers the two-flop line synchronisers
        check({7'h00, irq_o}, {7'h00, r[7:0] != 8'h00});
        xfer(1'b0, r[15:8], r[7:0]);
        xfer(1'b0, r[15:8], 8'h00);
        check({7'h00, irq_o}, 8'h00);
    endtask

    initial begin
        tbl = '{32'h0B005000,
                32'h00005080, 32'h01005040,
                32'h02005020, 32'h03005020,
                32'h05005010, 32'h04005010,
                32'h06005000, 32'h07005002,
                32'h09005001, 32'h1F045008,
                32'h0C005180, 32'h0D005120,
                32'h0E015100, 32'h0E005120, 32'h0F005120,
                32'h10005110, 32'h11005110,
                32'h12005108,
                32'h13025100, 32'h13005104,
                32'h1F085140, 32'h1F105201,
                32'h1F205202, 32'h1F205200};
        repeat (6) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        xfer(1'b0, `IDX_EVENT_MASK_0, `RST_EVENT_MASK_0);
        xfer(1'b0, `IDX_EVENT_MASK_1, `RST_EVENT_MASK_1);
        xfer(1'b0, `IDX_EVENT_MASK_2, `RST_EVENT_MASK_2);
        xfer(1'b0, `IDX_EVENT_STATUS_2, 8'h00);
        xfer(1'b0, `IDX_CONTROL, 8'h60);
        // random masks read back with their fixed bits
        repeat (4) begin
            v = 8'($random(seed));
            xfer(1'b1, `IDX_EVENT_MASK_1, v);
            xfer(1'b0, `IDX_EVENT_MASK_1, v | 8'h01);
            xfer(1'b1, `IDX_EVENT_MASK_2, v);
            xfer(1'b0, `IDX_EVENT_MASK_2, v | 8'hFC);
        end
        xfer(1'b1, 8'h57, 8'hA5);
        xfer(1'b0, 8'h57, 8'h00);
        xfer(1'b1, `IDX_CONTROL, 8'hF6);
        xfer(1'b0, `IDX_CONTROL, 8'h76);
        xfer(1'b1, `IDX_EVENT_MASK_0, 8'h00);
        xfer(1'b1, `IDX_EVENT_MASK_1, 8'h00);
        xfer(1'b1, `IDX_EVENT_MASK_2, 8'h00);
        // data lost in a frame that then ends
        pulse2(20'h00001, 20'h00100);
        xfer(1'b0, `IDX_EVENT_STATUS_0, 8'h84);
        foreach (tbl[e]) ev(tbl[e]);
        xfer(1'b0, `IDX_LINE_STATUS, 8'h03);
        // a masked timer event is discarded, then shown but still silent
        xfer(1'b1, `IDX_EVENT_MASK_1, 8'h80);
        ev(32'h0C005100);
        xfer(1'b1, `IDX_CONTROL, 8'h77);
        pulse2(20'h01000, 20'h00000);
        check({7'h00, irq_o}, 8'h00);
        xfer(1'b0, `IDX_EVENT_STATUS_1, 8'h80);
        // signal units: 255 stay quiet, the 256th wraps the counter
        repeat (127) pulse2(20'h00400, 20'h00400);
        pulse2(20'h00400, 20'h00000);
        xfer(1'b0, `IDX_EVENT_STATUS_1, 8'h00);
        ev(32'h0A005102);
        xfer(1'b0, `IDX_SU_COUNT, 8'h00);
        wrap_up();
    end
endmodule
`default_nettype wire
